// [src/emr_bank.v]
// Per-channel register bank: eye readout, tap override, driver options
// Assumes an SMBus slave front end giving reg address, write strobe,
// read strobe (one pulse per byte) and a new-transaction marker.
// Operation
// - Channel select picks visible register set
// - Bits 7:6 of eye_range_power_tap_polarity choose range
// - Clear eye_range_power_tap_polarity bit 5 powers eye monitor
// - fast_eye_control bit 7 enables fast mode
// - fast_eye_control bit 1 starts sweep
// - Multi-byte reads of eye_count_upper stream data
// - Single-byte: upper at eye_count_upper, lower eye_count_lower
// - Next count loads after both bytes read
// - Sweep covers 64 by 64 offsets
// - lock_monitor_control bit 7 re-enables lock monitoring
// - Tap override bit resets to one
// - feedback_eq_power bit 3 powers down equalizer
// - manual_tap_enable bit 7 applies manual taps
// - first_tap_weight_polarity holds tap one weight, sign
// - Taps 2-5 weights at 0x20-0x21, polarities in eye_range_power_tap_polarity
// - Linear boost may readapt after lock loss
// - Modes 2,3 adapt on state machine reset
// - Set-then-clear fast_eye_control bit 2 adapts taps
// - 0x71-0x75 report live tap values
// - No better merit keeps starting taps
// - Set-then-clear linear_eq_adapt_control bit 0 adapts boost; here only leq_adapt_go pulses, leq_boost loads on leq_relock alone
// - driver_slew_control bit 2 selects slow slew
// - output_polarity_control bit 7 inverts output
`include "emr_consts.vh"
module emr_bank #(
    parameter NCH  = 2,
    parameter CW   = 16,
    parameter PW   = 6
) (
    input  wire          clk_sys,
    input  wire          resetn,
    // Register port from the bus front end
    input  wire [7:0]    reg_addr,
    input  wire [7:0]    reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    input  wire          reg_start,
    input  wire          multi_byte,
    // Eye counter and recovery logic
    input  wire [CW-1:0] eye_count_in,
    input  wire          eye_count_valid,
    input  wire          cdr_reset,
    input  wire          cdr_eye_power,
    // Equalizer adaptation engine
    input  wire          adapt_done,
    input  wire          adapt_better,
    input  wire [1:0]    leq_fallback_in,
    input  wire          leq_relock,
    input  wire [3:0]    leq_boost_in,
    input  wire [25:0]   tap_adapted,
    // Register read data
    output reg  [7:0]    reg_rdata,
    // Eye monitor controls
    output reg  [1:0]    eye_range,
    output reg           eye_power,
    output reg           sweep_active,
    output reg           sweep_step,
    output reg  [PW-1:0] phase_off,
    output reg  [PW-1:0] volt_off,
    // Equalizer and driver controls
    output reg           lock_mon_en,
    output reg           feq_powerdown,
    output reg  [25:0]   tap_applied,
    output reg           feq_adapt_go,
    output reg           leq_adapt_go,
    output reg  [3:0]    leq_boost,
    output reg           slow_slew,
    output reg           out_invert
);

    // Tap vector width: tap one has a five-bit weight, the rest four,
    // and every tap carries a sign bit just above its weight
    localparam TW = 26;

    // Words thrown away after a start; two words are the four junk bytes
    localparam [2:0] JUNK = `EMR_JUNK_WORDS;

    // Last cell of the sweep; the array is 64 phases by 64 voltages
    localparam [2*PW-1:0] LAST_PT = {2*PW{1'b1}};

    // Per-channel register storage, indexed by the selected channel
    reg [7:0] r11_q [0:NCH-1];
    reg [7:0] r12_q [0:NCH-1];
    reg [7:0] r15_q [0:NCH-1];
    reg [7:0] r18_q [0:NCH-1];
    reg [7:0] r1e_q [0:NCH-1];
    reg [7:0] r1f_q [0:NCH-1];
    reg [7:0] r20_q [0:NCH-1];
    reg [7:0] r21_q [0:NCH-1];
    reg [7:0] r22_q [0:NCH-1];
    reg [7:0] r23_q [0:NCH-1];
    reg [7:0] r24_q [0:NCH-1];
    reg [7:0] r2f_q [0:NCH-1];
    reg [7:0] r31_q [0:NCH-1];
    reg [7:0] r3e_q [0:NCH-1];
    // Taps in use per channel, manual or adapted
    reg [TW-1:0] tap_live_q [0:NCH-1];
    // Channel choice, shared by every channel's register set
    reg [7:0]  chan_q;

    // Read-out state of the fast eye sweep
    reg [CW-1:0] hold_q;
    reg [1:0]  rd_phase_q;
    reg        got_hi_q;
    reg        got_lo_q;
    reg        lo_pend_q;
    reg [2:0]  junk_q;
    // Adaptation trigger edges and starting taps
    reg        feq_prev_q;
    reg        leq_prev_q;
    reg        adapting_q;
    reg [TW-1:0] start_taps_q;

    // Sweep position; the upper half is phase, the lower voltage
    reg [2*PW-1:0] point_q;
    reg        full_q;
    integer    i;
    wire [0:0] ch;
    wire       wr_any;
    assign ch = chan_q[0];
    assign wr_any = reg_wr;

    // Observation and live tap values, tap one in the low six bits
    wire [TW-1:0] live;
    assign live = tap_live_q[ch];

    // Observation bytes, one per tap: sign in bit 7, weight below
    wire [7:0] obs1;
    wire [7:0] obs2;
    wire [7:0] obs3;
    wire [7:0] obs4;
    wire [7:0] obs5;
    assign obs1 = {live[5], 2'b00, live[4:0]};
    assign obs2 = {live[10], 3'b000, live[9:6]};
    assign obs3 = {live[15], 3'b000, live[14:11]};
    assign obs4 = {live[20], 3'b000, live[19:16]};
    assign obs5 = {live[25], 3'b000, live[24:21]};

    // Register writes; channel select retargets later accesses
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_q <= 8'h00;
            for (i = 0; i < NCH; i = i + 1) begin
                r11_q[i] <= `EMR_R_RANGE_PWR;
                r12_q[i] <= `EMR_R_ZERO;
                r15_q[i] <= `EMR_R_ZERO;
                r18_q[i] <= `EMR_R_ZERO;
                r1e_q[i] <= `EMR_R_ZERO;
                r1f_q[i] <= `EMR_R_ZERO;
                r20_q[i] <= `EMR_R_ZERO;
                r21_q[i] <= `EMR_R_ZERO;
                r22_q[i] <= `EMR_R_ZERO;
                r23_q[i] <= `EMR_R_TAP_OV;
                r24_q[i] <= `EMR_R_ZERO;
                r2f_q[i] <= `EMR_R_ZERO;
                r31_q[i] <= `EMR_R_ADAPT_MODE;
                r3e_q[i] <= `EMR_R_LOCK_MON;
            end
        end else if (wr_any) begin
            // Writes land in the selected channel's set only; channel select is shared
            case (reg_addr)
                `EMR_A_CHAN_SEL:  chan_q <= reg_wdata;
                `EMR_A_RANGE_PWR: r11_q[ch] <= reg_wdata;
                `EMR_A_TAP1:      r12_q[ch] <= reg_wdata;
                `EMR_A_MANUAL:    r15_q[ch] <= reg_wdata;
                `EMR_A_SLEW:      r18_q[ch] <= reg_wdata;
                `EMR_A_FEQ_PWR:   r1e_q[ch] <= reg_wdata;
                `EMR_A_OUT_POL:   r1f_q[ch] <= reg_wdata;
                `EMR_A_TAPS_LO:   r20_q[ch] <= reg_wdata;
                `EMR_A_TAPS_HI:   r21_q[ch] <= reg_wdata;
                `EMR_A_EYE_OV:    r22_q[ch] <= reg_wdata;
                `EMR_A_TAP_OV:    r23_q[ch] <= reg_wdata;
                `EMR_A_FAST:      r24_q[ch] <= reg_wdata;
                `EMR_A_LEQ_ADAPT: r2f_q[ch] <= reg_wdata;
                `EMR_A_ADAPT_MODE: r31_q[ch] <= reg_wdata;
                `EMR_A_LOCK_MON:  r3e_q[ch] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Manual tap vector from the weight and polarity registers
    // Each tap keeps its sign just above its weight
    wire [TW-1:0] manual_taps;
    assign manual_taps = {r11_q[ch][3], r21_q[ch][7:4],
                          r11_q[ch][2], r21_q[ch][3:0],
                          r11_q[ch][1], r20_q[ch][7:4],
                          r11_q[ch][0], r20_q[ch][3:0],
                          r12_q[ch][7], r12_q[ch][4:0]};

    // Adaptation triggers: falling edge of host bits, or for taps only a reset in mode 2/3
    wire feq_bit;
    wire leq_bit;
    wire auto_feq;
    assign feq_bit  = r24_q[ch][`EMR_B_FEQ_GO];
    assign leq_bit  = r2f_q[ch][`EMR_B_LEQ_GO];
    assign auto_feq = cdr_reset & r31_q[ch][6];
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            feq_prev_q   <= 1'b0;
            leq_prev_q   <= 1'b0;
            feq_adapt_go <= 1'b0;
            leq_adapt_go <= 1'b0;
            adapting_q   <= 1'b0;
            start_taps_q <= {TW{1'b0}};
            leq_boost    <= 4'h0;
            for (i = 0; i < NCH; i = i + 1)
                tap_live_q[i] <= {TW{1'b0}};
        end else begin
            feq_prev_q   <= feq_bit;
            leq_prev_q   <= leq_bit;
            feq_adapt_go <= (feq_prev_q & ~feq_bit) | auto_feq;
            leq_adapt_go <= leq_prev_q & ~leq_bit;
            // Snapshot taps so a fruitless search can fall back
            if (feq_adapt_go) begin
                adapting_q   <= 1'b1;
                start_taps_q <= manual_taps;
            end else if (adapting_q && adapt_done) begin
                adapting_q <= 1'b0;
                // Keep the start point unless the search improved
                tap_live_q[ch] <= adapt_better ? tap_adapted
                                               : start_taps_q;
            end else if (!adapting_q && r15_q[ch][`EMR_B_TOP]) begin
                tap_live_q[ch] <= manual_taps;
            end
            // Boost may move on its own after a lock loss
            if (leq_relock)
                leq_boost <= leq_boost_in;
            else if (leq_adapt_go && leq_fallback_in == 2'b00)
                leq_boost <= leq_boost;
        end
    end

    // Fast eye sweep: stepping through 64x64 points, two bytes each
    wire fast_en;
    wire go_wr;
    wire rd_hi;
    wire rd_lo;
    assign fast_en = r24_q[ch][`EMR_B_FAST_EN];
    assign go_wr = wr_any && reg_addr == `EMR_A_FAST &&
                   reg_wdata[`EMR_B_FAST_GO] &&
                   reg_wdata[`EMR_B_FAST_EN];
    assign rd_hi = reg_rd && reg_addr == `EMR_A_CNT_HI;
    assign rd_lo = reg_rd && reg_addr == `EMR_A_CNT_LO;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sweep_active <= 1'b0;
            sweep_step   <= 1'b0;
            point_q      <= {2*PW{1'b0}};
            hold_q       <= {CW{1'b0}};
            got_hi_q     <= 1'b0;
            got_lo_q     <= 1'b0;
            lo_pend_q    <= 1'b0;
            junk_q       <= 3'd0;
            full_q       <= 1'b0;
            rd_phase_q   <= 2'd0;
        end else begin
            sweep_step <= 1'b0;
            // A start drops any half-read word
            if (go_wr) begin
                sweep_active <= 1'b1;
                point_q      <= {2*PW{1'b0}};
                hold_q       <= {CW{1'b0}};
                got_hi_q     <= 1'b0;
                got_lo_q     <= 1'b0;
                lo_pend_q    <= 1'b0;
                junk_q       <= JUNK;
                full_q       <= 1'b0;
            end else if (!fast_en) begin
                sweep_active <= 1'b0;
            end else if (sweep_active) begin
                // Second eye_count_upper read of a word returns its low byte
                if (rd_hi && multi_byte && lo_pend_q) begin
                    lo_pend_q <= 1'b0;
                    got_lo_q  <= 1'b1;
                end else if (rd_hi) begin
                    got_hi_q  <= 1'b1;
                    lo_pend_q <= multi_byte;
                    sweep_step <= 1'b1;
                end else if (rd_lo) begin
                    got_lo_q <= 1'b1;
                end
                // New count only after both halves were taken
                if (got_hi_q && got_lo_q && eye_count_valid && !full_q) begin
                    hold_q   <= eye_count_in;
                    got_hi_q <= 1'b0;
                    got_lo_q <= 1'b0;
                    if (junk_q != 3'd0)
                        junk_q <= junk_q - 3'd1;
                    else if (point_q == LAST_PT)
                        full_q <= 1'b1;
                    else
                        point_q <= point_q + 1'b1;
                end
                if (reg_start)
                    rd_phase_q <= 2'd0;
            end
        end
    end

    // Read mux; observation registers show the live tap state
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `EMR_A_CHAN_SEL:   reg_rdata <= chan_q;
                `EMR_A_RANGE_PWR:  reg_rdata <= r11_q[ch];
                `EMR_A_TAP1:       reg_rdata <= r12_q[ch];
                `EMR_A_MANUAL:     reg_rdata <= r15_q[ch];
                `EMR_A_SLEW:       reg_rdata <= r18_q[ch];
                `EMR_A_FEQ_PWR:    reg_rdata <= r1e_q[ch];
                `EMR_A_OUT_POL:    reg_rdata <= r1f_q[ch];
                `EMR_A_TAPS_LO:    reg_rdata <= r20_q[ch];
                `EMR_A_TAPS_HI:    reg_rdata <= r21_q[ch];
                `EMR_A_EYE_OV:     reg_rdata <= r22_q[ch];
                `EMR_A_TAP_OV:     reg_rdata <= r23_q[ch];
                `EMR_A_FAST:       reg_rdata <= r24_q[ch];
                // Multi-byte mode folds the low byte into eye_count_upper
                `EMR_A_CNT_HI:     reg_rdata <= (multi_byte && lo_pend_q)
                                                ? hold_q[7:0]
                                                : hold_q[15:8];
                `EMR_A_CNT_LO:     reg_rdata <= hold_q[7:0];
                `EMR_A_LEQ_ADAPT:  reg_rdata <= r2f_q[ch];
                `EMR_A_ADAPT_MODE: reg_rdata <= r31_q[ch];
                `EMR_A_LOCK_MON:   reg_rdata <= r3e_q[ch];
                // Tap observation bytes follow the live taps
                `EMR_A_OBS_FIRST:  reg_rdata <= obs1;
                `EMR_A_OBS_TAP2:   reg_rdata <= obs2;
                `EMR_A_OBS_TAP3:   reg_rdata <= obs3;
                `EMR_A_OBS_TAP4:   reg_rdata <= obs4;
                `EMR_A_OBS_LAST:   reg_rdata <= obs5;
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    // Controls driven to the analog side of the selected channel
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            eye_range     <= 2'b00;
            eye_power     <= 1'b0;
            phase_off     <= {PW{1'b0}};
            volt_off      <= {PW{1'b0}};
            lock_mon_en   <= 1'b1;
            feq_powerdown <= 1'b0;
            tap_applied   <= {TW{1'b0}};
            slow_slew     <= 1'b0;
            out_invert    <= 1'b0;
        end else begin
            eye_range   <= r11_q[ch][7:6];
            // Cleared bit forces power; set bit defers to recovery logic
            eye_power   <= ~r11_q[ch][`EMR_B_EYE_PWR] |
                           cdr_eye_power;
            // Offsets of the current sweep point
            phase_off   <= point_q[2*PW-1:PW];
            volt_off    <= point_q[PW-1:0];
            lock_mon_en <= r3e_q[ch][`EMR_B_TOP];
            feq_powerdown <= r1e_q[ch][`EMR_B_FEQ_PD];
            // Powered-down equalizer sees zero taps
            tap_applied <= r1e_q[ch][`EMR_B_FEQ_PD] ? {TW{1'b0}}
                                                    : live;
            // Driver options
            slow_slew   <= r18_q[ch][`EMR_B_SLEW];
            out_invert  <= r1f_q[ch][`EMR_B_TOP];
        end
    end
endmodule

// [inc/emr_consts.vh]
// Register map constants for the eye monitor readout and tap override bank
// Assumes an 8-bit register port fed by an external SMBus slave front end
`ifndef EMR_CONSTS_VH
`define EMR_CONSTS_VH
`define EMR_A_RANGE_PWR   8'h11
`define EMR_A_TAP1        8'h12
`define EMR_A_MANUAL      8'h15
`define EMR_A_SLEW        8'h18
`define EMR_A_FEQ_PWR     8'h1E
`define EMR_A_OUT_POL     8'h1F
`define EMR_A_TAPS_LO     8'h20
`define EMR_A_TAPS_HI     8'h21
`define EMR_A_EYE_OV      8'h22
`define EMR_A_TAP_OV      8'h23
`define EMR_A_FAST        8'h24
`define EMR_A_CNT_HI      8'h25
`define EMR_A_CNT_LO      8'h26
`define EMR_A_LEQ_ADAPT   8'h2F
`define EMR_A_ADAPT_MODE  8'h31
`define EMR_A_LOCK_MON    8'h3E
`define EMR_A_OBS_FIRST   8'h71
`define EMR_A_OBS_TAP2    8'h72
`define EMR_A_OBS_TAP3    8'h73
`define EMR_A_OBS_TAP4    8'h74
`define EMR_A_OBS_LAST    8'h75
`define EMR_A_CHAN_SEL    8'hFF
`define EMR_B_EYE_PWR     5
`define EMR_B_FAST_EN     7
`define EMR_B_FAST_GO     1
`define EMR_B_FEQ_GO      2
`define EMR_B_LEQ_GO      0
`define EMR_B_TOP         7
`define EMR_B_TAP_OV      6
`define EMR_B_FEQ_PD      3
`define EMR_B_SLEW        2
`define EMR_R_RANGE_PWR   8'h20
`define EMR_R_TAP_OV      8'h40
`define EMR_R_LOCK_MON    8'h80
`define EMR_R_ADAPT_MODE  8'h40
`define EMR_R_ZERO        8'h00
`define EMR_JUNK_WORDS    2
`endif

// [test/emr_bank_props.sv]
// Checker for the eye readout and tap override bank
// Assumes a bind into emr_bank; outputs judged after channel 0 writes
module emr_bank_props (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [1:0] eye_range,
    input wire logic       eye_power,
    input wire logic       sweep_active,
    input wire logic       lock_mon_en,
    input wire logic       feq_powerdown,
    input wire logic       leq_adapt_go,
    input wire logic       slow_slew,
    input wire logic       out_invert
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sel_q;
    logic arm_q;
    wire  w0 = reg_wr && !sel_q;
    // Mirror channel choice, so only writes made while channel 0 is selected are judged
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 1'b0;
            arm_q <= 1'b0;
        end else if (reg_wr && reg_addr == 8'hFF) begin
            sel_q <= reg_wdata[0];
        end else if (w0 && reg_addr == 8'h2F) begin
            arm_q <= reg_wdata[0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Two cycles allow for a register stage behind the field
    chk_range_field: assert property (
        w0 && reg_addr == 8'h11 |-> ##2 eye_range == $past(reg_wdata[7:6], 2))
        else $error("eye range not taken");
    chk_eye_forced: assert property (
        w0 && reg_addr == 8'h11 && !reg_wdata[5] |-> ##2 eye_power)
        else $error("eye monitor not powered");
    chk_sweep_go: assert property (
        w0 && reg_addr == 8'h24 && reg_wdata[7] && reg_wdata[1]
        |-> ##[1:2] sweep_active) else $error("sweep did not start");
    chk_lock_mon: assert property (
        w0 && reg_addr == 8'h3E |-> ##2 lock_mon_en == $past(reg_wdata[7], 2))
        else $error("lock monitor bit not applied");
    chk_feq_off: assert property (
        w0 && reg_addr == 8'h1E |-> ##2 feq_powerdown == $past(reg_wdata[3], 2))
        else $error("equalizer power bit not applied");
    chk_slew_bit: assert property (
        w0 && reg_addr == 8'h18 |-> ##2 slow_slew == $past(reg_wdata[2], 2))
        else $error("slew bit not applied");
    chk_invert_bit: assert property (
        w0 && reg_addr == 8'h1F |-> ##2 out_invert == $past(reg_wdata[7], 2))
        else $error("invert bit not applied");
    chk_boost_go: assert property (
        w0 && reg_addr == 8'h2F && !reg_wdata[0] && arm_q
        |-> ##[1:3] leq_adapt_go) else $error("boost adapt not started");
endmodule
bind emr_bank emr_bank_props u_props (.clk_sys, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .eye_range, .eye_power, .sweep_active,
    .lock_mon_en, .feq_powerdown, .leq_adapt_go, .slow_slew, .out_invert);

// [test/emr_host_model.sv]
// Host controller model: byte writes and reads on the register port
// Assumes the bank samples strobes on the rising clock edge
module emr_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr   = 8'h00,
    output logic      [7:0] reg_wdata  = 8'h00,
    output logic            reg_wr     = 1'b0,
    output logic            reg_rd     = 1'b0,
    output logic            reg_start  = 1'b0,
    output logic            multi_byte = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus shows inverted leftovers so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // Fresh addressing before the byte when st is set
    task automatic rd(input logic [7:0] a, input logic st,
                      output logic [7:0] d);
        @(negedge clk_sys);
        reg_start = st;
        @(negedge clk_sys);
        reg_start = 1'b0;
        reg_addr  = a;
        reg_rd    = 1'b1;
        @(negedge clk_sys);
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the eye readout and tap override bank
// Assumes the host model owns the register port; channel 0 watched
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [15:0] eye_count_in = 16'hC3A5;
    logic        cdr_reset = 1'b0;
    logic        cdr_eye_power = 1'b0;
    logic        adapt_done = 1'b0;
    logic        adapt_better = 1'b0;
    logic [25:0] tap_adapted = 26'h0000000;
    logic        leq_relock = 1'b0;
    logic [3:0]  leq_boost_in = 4'h0;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire  [1:0]  eye_range;
    wire         reg_wr, reg_rd, reg_start, multi_byte, eye_power;
    wire         sweep_active, lock_mon_en, feq_powerdown, feq_adapt_go;
    wire         leq_adapt_go, slow_slew, out_invert;
    wire         sweep_step;
    wire  [5:0]  phase_off, volt_off;
    wire  [25:0] tap_applied;
    wire  [3:0]  leq_boost;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n_feq = 0;
    int          n_leq = 0;
    int          n_step = 0;
    logic [7:0]  d;
    logic [7:0]  ra [12] = '{8'h11, 8'h12, 8'h15, 8'h18, 8'h1E, 8'h1F,
                             8'h20, 8'h21, 8'h22, 8'h23, 8'h31, 8'h3E};
    logic [7:0]  rv [12] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h80};
    logic [7:0]  wa [7] = '{8'h12, 8'h15, 8'h18, 8'h1E, 8'h1F, 8'h20, 8'h21};
    logic [7:0]  wv [7] = '{8'h9F, 8'h80, 8'h04, 8'h08, 8'h80, 8'hFF, 8'hFF};
    emr_bank uut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_start, .multi_byte, .eye_count_in,
        .eye_count_valid(1'b1), .cdr_reset, .cdr_eye_power, .adapt_done,
        .adapt_better, .leq_fallback_in(2'h0), .leq_relock,
        .leq_boost_in, .tap_adapted, .reg_rdata, .eye_range,
        .eye_power, .sweep_active, .sweep_step, .phase_off,
        .volt_off, .lock_mon_en, .feq_powerdown, .tap_applied,
        .feq_adapt_go, .leq_adapt_go, .leq_boost, .slow_slew,
        .out_invert);
    emr_host_model host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_start, .multi_byte);
    always #2.5 clk_sys = ~clk_sys;
    // Count adapt pulses; a hung run is cut well past the expected length
    always @(posedge clk_sys) begin
        cycles++;
        if (feq_adapt_go === 1'b1)
            n_feq++;
        if (leq_adapt_go === 1'b1)
            n_leq++;
        if (sweep_step === 1'b1)
            n_step++;
        if (cycles == 5000) begin
            n_mismatch++;
            results;
        end
    end
    task automatic results;
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic st,
                      input logic [7:0] want);
        logic [7:0] v;
        host.rd(a, st, v);
        check(v, want);
    endtask
    task automatic settle;
        repeat (3) @(negedge clk_sys);
    endtask
    // Main sequence: reset values, taps, channels, adapt, eye readout
    initial begin
        repeat (12) @(negedge clk_sys);
        resetn = 1'b1;
        check(lock_mon_en, 8'h01);
        for (int i = 0; i < 12; i++)
            rc(ra[i], 1'b1, rv[i]);
        rc(8'h71, 1'b1, 8'h00);
        for (int i = 0; i < 7; i++) begin
            host.wr(wa[i], wv[i]);
            rc(wa[i], 1'b1, wv[i]);
        end
        check(slow_slew, 8'h01);
        check(out_invert, 8'h01);
        check(feq_powerdown, 8'h01);
        check(8'(tap_applied), 8'h00);
        host.wr(8'h1E, 8'h00);
        rc(8'h71, 1'b1, 8'h9F);
        check(8'(tap_applied), 8'hFF);
        host.wr(8'hFF, 8'h01);
        rc(8'h18, 1'b1, 8'h00);
        host.wr(8'hFF, 8'h00);
        rc(8'h18, 1'b1, 8'h04);
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h11, 8'(m << 6));
            settle;
            check(eye_range, 8'(m));
            check(eye_power, 8'h01);
        end
        host.wr(8'h11, 8'h20);
        settle;
        check(eye_power, 8'h00);
        cdr_eye_power = 1'b1;
        settle;
        check(eye_power, 8'h01);
        // Every adapt mode; only the upper two adapt on a recovery reset
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h31, 8'(m << 5));
            n_feq = 0;
            cdr_reset = 1'b1;
            @(negedge clk_sys);
            cdr_reset = 1'b0;
            settle;
            check(8'(n_feq), 8'(m >= 2));
        end
        host.wr(8'h12, 8'h9F);
        host.wr(8'h15, 8'h00);
        n_feq = 0;
        host.wr(8'h24, 8'h04);
        host.wr(8'h24, 8'h00);
        settle;
        check(8'(n_feq), 8'h01);
        tap_adapted = 26'h3FFFFC0;
        adapt_done = 1'b1;
        @(negedge clk_sys);
        adapt_done = 1'b0;
        rc(8'h71, 1'b1, 8'h9F);
        n_leq = 0;
        host.wr(8'h2F, 8'h01);
        host.wr(8'h2F, 8'h00);
        settle;
        check(8'(n_leq), 8'h01);
        check(8'(leq_boost), 8'h00);
        leq_boost_in = 4'hA;
        leq_relock = 1'b1;
        @(negedge clk_sys);
        leq_relock = 1'b0;
        check(8'(leq_boost), 8'h0A);
        host.wr(8'h3E, 8'h00);
        host.wr(8'h11, 8'hC0);
        host.wr(8'h22, 8'h00);
        host.wr(8'h24, 8'h82);
        settle;
        check(sweep_active, 8'h01);
        check(lock_mon_en, 8'h00);
        for (int i = 0; i < 4; i++)
            host.rd(8'h25 + 8'(i % 2), 1'b1, d);
        rc(8'h25, 1'b1, 8'hC3);
        eye_count_in = 16'h5A96;
        rc(8'h26, 1'b1, 8'hA5);
        rc(8'h25, 1'b1, 8'h5A);
        rc(8'h26, 1'b1, 8'h96);
        host.multi_byte = 1'b1;
        rc(8'h25, 1'b1, 8'h5A);
        rc(8'h25, 1'b0, 8'h96);
        rc(8'h25, 1'b0, 8'h5A);
        rc(8'h25, 1'b1, 8'h96);
        host.multi_byte = 1'b0;
        host.wr(8'h24, 8'h00);
        host.wr(8'h11, 8'h20);
        host.wr(8'h3E, 8'h80);
        settle;
        check(sweep_active, 8'h00);
        check(lock_mon_en, 8'h01);
        check(8'(n_step), 8'h06);
        check(8'(volt_off), 8'h04);
        check(8'(phase_off), 8'h00);
        results;
    end
endmodule
